// ===== ccu_pkg.sv
// constants, register map and mode codes for the capture/compare unit
package ccu_pkg;
  localparam int NUM_CH = 16;
  localparam int NUM_TMR = 2;
  localparam int NUM_IRQ = 18;
  // register byte addresses and channel block selects for address bits 7:6; timer registers step by 4 per timer
  localparam logic [7:0] ADR_T_CTRL = 8'h00;
  localparam logic [7:0] ADR_T_CNT = 8'h08;
  localparam logic [7:0] ADR_T_REL = 8'h10;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h18;
  localparam logic [7:0] ADR_IRQ_CLR = 8'h1C;
  localparam logic [7:0] ADR_IRQ_EN = 8'h20;
  localparam logic [7:0] ADR_GLOBAL = 8'h24;
  localparam logic [1:0] ADR_CH_CTRL_SEL = 2'h1;
  localparam logic [1:0] ADR_CH_VAL_SEL = 2'h2;
  // timer control fields
  localparam int TC_CLK_LSB = 0;
  localparam int TC_SRC_LSB = 3;
  localparam int TC_RUN_BIT = 5;
  localparam int TC_PRIO_LSB = 6;
  // channel control fields, then the global staggered mode bit
  localparam int CC_MODE_LSB = 0;
  localparam int CC_TSEL_BIT = 3;
  localparam int CC_DBL_BIT = 4;
  localparam int CC_SINGLE_BIT = 5;
  localparam int CC_PRIO_LSB = 6;
  localparam int GLB_STAGGER_BIT = 0;
  // values after reset, and the maximum count at which a timer reloads
  localparam logic [7:0] TCTRL_RST = 8'h00;
  localparam logic [7:0] CCTRL_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] REL_RST = 16'h0000;
  localparam logic [17:0] IRQ_EN_RST = 18'h00000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  // staggered mode: one count slot every 8 clocks
  localparam logic [2:0] STAGGER_LAST = 3'h7;
  typedef enum logic [2:0] {
    CC_OFF = 3'b000,
    CAP_RISE = 3'b001,
    CAP_FALL = 3'b010,
    CAP_BOTH = 3'b011,
    CMP_IRQ = 3'b100,
    CMP_TOGGLE = 3'b101,
    CMP_IRQ_ONCE = 3'b110,
    CMP_SET_RESET = 3'b111
  } ccu_mode_type;
  typedef enum logic [1:0] {
    SRC_PRESC = 2'b00,
    SRC_AUX = 2'b01,
    SRC_EXT_RISE = 2'b10,
    SRC_EXT_ANY = 2'b11
  } ccu_src_type;
endpackage

// ===== ccu_capture_compare.sv
// sixteen channel capture/compare unit with two reloading time bases
`timescale 1ns/1ps
// What this block does
// - sixteen channels, one-clock resolution, eight clocks in staggered mode
// - two independent 16-bit timers, each with its own reload register
// - timer clock from prescaled system clock or auxiliary timer overflows
// - timers may also count external count input edges
// - sixteen channel registers, each picks a timer and capture or compare
// - each channel owns one pin: capture input or compare output
// - capture latches the assigned timer on the selected pin event
// - each capture raises that channel's own interrupt request
// - capture edge selectable: rising, falling or both
// - compare channels watch their timer and act on equality
// - mode 0 match raises interrupt only, repeatable within a period
// - mode 1 match toggles the pin, repeatable within a period
// - mode 2 match raises one interrupt per timer period only
// - mode 3 sets pin on match, clears on overflow, once per period
// - double register mode: two channels toggle one shared pin
// - single event option stops a compare channel after its first match
// - each request has a node with request flag, enable and priority
module ccu_capture_compare (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic [15:0] i_pin,
  output logic [15:0] o_pin,
  output logic [15:0] o_pin_oe_n,
  input wire logic [1:0] i_ext_cnt,
  input wire logic i_aux_ovf,
  output logic [17:0] o_irq_node,
  output logic o_irq,
  output logic [1:0] o_irq_prio
);
  // pin and count input synchronisers; third stage only for edge detect
  logic [15:0] pin_s1_q, pin_s2_q, pin_s3_q;
  logic [1:0] ext_s1_q, ext_s2_q, ext_s3_q;
  logic [1:0] ext_rise, ext_any;
  logic [10:0] presc_q, presc_d;
  logic stag_q, stag_d;
  logic [15:0] cnt_q [2];
  logic [15:0] rel_q [2];
  logic [7:0] tctrl_q [2];
  logic tick_q [2];
  logic ovf_q [2];
  logic [7:0] ctrl_q [16];
  logic [15:0] val_q [16];
  logic [15:0] hit;
  logic [15:0] ev;
  logic [17:0] st_q, st_d, en_q, en_d;
  logic irq_q, irq_d;
  logic [1:0] prio_q, prio_d;
  logic [31:0] rdata_q, rdata_d;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pin_s1_q <= 16'h0000;
      pin_s2_q <= 16'h0000;
      pin_s3_q <= 16'h0000;
      ext_s1_q <= 2'h0;
      ext_s2_q <= 2'h0;
      ext_s3_q <= 2'h0;
    end else begin
      pin_s1_q <= i_pin;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      ext_s1_q <= i_ext_cnt;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  assign ext_rise = ext_s2_q & ~ext_s3_q;
  assign ext_any = ext_s2_q ^ ext_s3_q;

  // shared prescaler and staggered mode switch
  always_comb begin
    presc_d = presc_q + 11'h001;
    stag_d = stag_q;
    if (i_wr && i_addr == ccu_pkg::ADR_GLOBAL) begin
      stag_d = i_wdata[ccu_pkg::GLB_STAGGER_BIT];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      presc_q <= 11'h000;
      stag_q <= 1'b0;
    end else begin
      presc_q <= presc_d;
      stag_q <= stag_d;
    end
  end

  for (genvar t = 0; t < ccu_pkg::NUM_TMR; t++) begin : g_tmr
    localparam logic [7:0] OFS = 8'(4 * t);
    logic [7:0] mask;
    logic src_tick;
    logic inc;
    logic [15:0] cnt_d, rel_d;
    logic [7:0] tctrl_d;
    logic tick_d, ovf_d;

    always_comb begin
      mask = ~(8'hFF << tctrl_q[t][ccu_pkg::TC_CLK_LSB +: 3]);
      // staggered mode only lets the prescaled clock move the timer in the last of 8 slots
      if (stag_q) begin
        src_tick = presc_q[2:0] == ccu_pkg::STAGGER_LAST && (presc_q[10:3] & mask) == mask;
      end else begin
        src_tick = (presc_q[7:0] & mask) == mask;
      end
      case (ccu_pkg::ccu_src_type'(tctrl_q[t][ccu_pkg::TC_SRC_LSB +: 2]))
        ccu_pkg::SRC_PRESC: inc = src_tick;
        ccu_pkg::SRC_AUX: inc = i_aux_ovf;
        ccu_pkg::SRC_EXT_RISE: inc = ext_rise[t];
        ccu_pkg::SRC_EXT_ANY: inc = ext_any[t];
        default: inc = 1'b0;
      endcase
      inc = inc && tctrl_q[t][ccu_pkg::TC_RUN_BIT];
      cnt_d = cnt_q[t];
      rel_d = rel_q[t];
      tctrl_d = tctrl_q[t];
      tick_d = inc;
      ovf_d = 1'b0;
      if (inc) begin
        if (cnt_q[t] == ccu_pkg::CNT_MAX) begin
          cnt_d = rel_q[t];
          ovf_d = 1'b1;
        end else begin
          cnt_d = cnt_q[t] + 16'h0001;
        end
      end
      // software count write overrides the increment in the same cycle
      if (i_wr && i_addr == ccu_pkg::ADR_T_CNT + OFS) begin
        cnt_d = i_wdata[15:0];
      end
      if (i_wr && i_addr == ccu_pkg::ADR_T_REL + OFS) begin
        rel_d = i_wdata[15:0];
      end
      if (i_wr && i_addr == ccu_pkg::ADR_T_CTRL + OFS) begin
        tctrl_d = i_wdata[7:0];
      end
    end

    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        cnt_q[t] <= ccu_pkg::CNT_RST;
        rel_q[t] <= ccu_pkg::REL_RST;
        tctrl_q[t] <= ccu_pkg::TCTRL_RST;
        tick_q[t] <= 1'b0;
        ovf_q[t] <= 1'b0;
      end else begin
        cnt_q[t] <= cnt_d;
        rel_q[t] <= rel_d;
        tctrl_q[t] <= tctrl_d;
        tick_q[t] <= tick_d;
        ovf_q[t] <= ovf_d;
      end
    end
  end

  for (genvar c = 0; c < ccu_pkg::NUM_CH; c++) begin : g_ch
    // lower eight channels may be paired with channel c+8
    localparam int PC = (c + 8) % 16;
    localparam logic [3:0] IDX = 4'(c);
    ccu_pkg::ccu_mode_type mode;
    logic tsel, single, is_cmp, partner_dbl, own_dbl;
    logic rise, fall, cap_ev, hit_c;
    logic [7:0] ctrl_d;
    logic [15:0] val_d;
    logic pin_q, pin_d, lock_q, lock_d;

    always_comb begin
      mode = ccu_pkg::ccu_mode_type'(ctrl_q[c][ccu_pkg::CC_MODE_LSB +: 3]);
      tsel = ctrl_q[c][ccu_pkg::CC_TSEL_BIT];
      single = ctrl_q[c][ccu_pkg::CC_SINGLE_BIT];
      is_cmp = mode[2];
      own_dbl = c >= 8 && ctrl_q[c][ccu_pkg::CC_DBL_BIT];
      partner_dbl = c < 8 && ctrl_q[PC][ccu_pkg::CC_DBL_BIT] && ctrl_q[PC][2];
      rise = pin_s2_q[c] && !pin_s3_q[c];
      fall = !pin_s2_q[c] && pin_s3_q[c];
      case (mode)
        ccu_pkg::CAP_RISE: cap_ev = rise;
        ccu_pkg::CAP_FALL: cap_ev = fall;
        ccu_pkg::CAP_BOTH: cap_ev = rise || fall;
        default: cap_ev = 1'b0;
      endcase
      // compare only on a fresh timer value, so a stalled timer fires once
      hit_c = is_cmp && tick_q[tsel] && cnt_q[tsel] == val_q[c] && !lock_q;
      ctrl_d = ctrl_q[c];
      val_d = val_q[c];
      if (i_wr && i_addr[7:6] == ccu_pkg::ADR_CH_CTRL_SEL && i_addr[5:2] == IDX) begin
        ctrl_d = i_wdata[7:0];
      end
      if (i_wr && i_addr[7:6] == ccu_pkg::ADR_CH_VAL_SEL && i_addr[5:2] == IDX) begin
        val_d = i_wdata[15:0];
      end
      if (cap_ev) begin
        val_d = cnt_q[tsel];
      end
      // a changed channel control value re-arms a locked channel
      lock_d = lock_q;
      if (ctrl_d != ctrl_q[c]) begin
        lock_d = 1'b0;
      end else if (ovf_q[tsel] && !single) begin
        lock_d = 1'b0;
      end
      if (hit_c && (single || mode == ccu_pkg::CMP_IRQ_ONCE || mode == ccu_pkg::CMP_SET_RESET)) begin
        lock_d = 1'b1;
      end
      pin_d = pin_q;
      if (mode == ccu_pkg::CMP_TOGGLE && !own_dbl && hit_c) begin
        pin_d = !pin_q;
      end
      if (partner_dbl && (hit_c || hit[PC])) begin
        pin_d = !pin_q;
      end
      // match applied last so it wins over an overflow in the same cycle
      if (mode == ccu_pkg::CMP_SET_RESET && !own_dbl) begin
        if (ovf_q[tsel]) begin
          pin_d = 1'b0;
        end
        if (hit_c) begin
          pin_d = 1'b1;
        end
      end
    end

    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        ctrl_q[c] <= ccu_pkg::CCTRL_RST;
        val_q[c] <= ccu_pkg::CNT_RST;
        pin_q <= 1'b0;
        lock_q <= 1'b0;
      end else begin
        ctrl_q[c] <= ctrl_d;
        val_q[c] <= val_d;
        pin_q <= pin_d;
        lock_q <= lock_d;
      end
    end

    assign hit[c] = hit_c;
    // modes 0 and 2 leave the pin alone unless paired; every match and capture requests
    assign ev[c] = hit_c || cap_ev;
    assign o_pin[c] = pin_q;
    // a paired upper channel leaves its pin to the lower one
    assign o_pin_oe_n[c] = !(partner_dbl || (!own_dbl &&
      (mode == ccu_pkg::CMP_TOGGLE || mode == ccu_pkg::CMP_SET_RESET)));
  end

  // interrupt nodes: channels 0..15, timer overflows 16..17
  always_comb begin
    logic [1:0] p;
    logic [17:0] act;
    p = 2'h0;
    act = 18'h00000;
    st_d = st_q;
    en_d = en_q;
    if (i_wr && i_addr == ccu_pkg::ADR_IRQ_CLR) begin
      st_d = st_q & ~i_wdata[17:0];
    end
    // a new event wins over a clear in the same cycle
    st_d = st_d | {ovf_q[1], ovf_q[0], ev};
    if (i_wr && i_addr == ccu_pkg::ADR_IRQ_EN) begin
      en_d = i_wdata[17:0];
    end
    act = st_d & en_d;
    irq_d = |act;
    prio_d = 2'h0;
    for (int n = 0; n < ccu_pkg::NUM_IRQ; n++) begin
      if (n < ccu_pkg::NUM_CH) begin
        p = ctrl_q[n][ccu_pkg::CC_PRIO_LSB +: 2];
      end else begin
        p = tctrl_q[n - ccu_pkg::NUM_CH][ccu_pkg::TC_PRIO_LSB +: 2];
      end
      if (act[n] && p > prio_d) begin
        prio_d = p;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_q <= 18'h00000;
      en_q <= ccu_pkg::IRQ_EN_RST;
      irq_q <= 1'b0;
      prio_q <= 2'h0;
    end else begin
      st_q <= st_d;
      en_q <= en_d;
      irq_q <= irq_d;
      prio_q <= prio_d;
    end
  end

  // status stays until software clears it; enable only masks the output
  assign o_irq_node = st_q & en_q;
  assign o_irq = irq_q;
  assign o_irq_prio = prio_q;

  // read mux; unmapped and write-only addresses read as zero
  always_comb begin
    rdata_d = 32'h00000000;
    if (i_rd) begin
      if (i_addr[7:6] == ccu_pkg::ADR_CH_CTRL_SEL) begin
        rdata_d = {24'h000000, ctrl_q[i_addr[5:2]]};
      end else if (i_addr[7:6] == ccu_pkg::ADR_CH_VAL_SEL) begin
        rdata_d = {16'h0000, val_q[i_addr[5:2]]};
      end else begin
        case (i_addr)
          ccu_pkg::ADR_T_CTRL: rdata_d = {24'h000000, tctrl_q[0]};
          ccu_pkg::ADR_T_CTRL + 8'h04: rdata_d = {24'h000000, tctrl_q[1]};
          ccu_pkg::ADR_T_CNT: rdata_d = {16'h0000, cnt_q[0]};
          ccu_pkg::ADR_T_CNT + 8'h04: rdata_d = {16'h0000, cnt_q[1]};
          ccu_pkg::ADR_T_REL: rdata_d = {16'h0000, rel_q[0]};
          ccu_pkg::ADR_T_REL + 8'h04: rdata_d = {16'h0000, rel_q[1]};
          ccu_pkg::ADR_IRQ_STAT: rdata_d = {14'h0000, st_q};
          ccu_pkg::ADR_IRQ_EN: rdata_d = {14'h0000, en_q};
          ccu_pkg::ADR_GLOBAL: rdata_d = {31'h00000000, stag_q};
          default: rdata_d = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // answer stands for one cycle only, then the mux falls back to zero
  assign o_rdata = rdata_q;
endmodule

// ===== ccu_capture_compare_monitor.sv
// port checker for the capture/compare unit, bound to its top module
`timescale 1ns/1ps
module ccu_capture_compare_monitor (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic [15:0] o_pin,
  input wire logic [15:0] o_pin_oe_n,
  input wire logic [17:0] o_irq_node,
  input wire logic o_irq,
  input wire logic [1:0] o_irq_prio
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_en_wr;
    i_wr && i_addr == ccu_pkg::ADR_IRQ_EN;
  endsequence
  sequence s_en_rd;
    i_rd && i_addr == ccu_pkg::ADR_IRQ_EN;
  endsequence
  a_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside a read answer");
  a_irq_any_node: assert property (o_irq == (|o_irq_node))
    else $error("irq does not follow the nodes");
  a_prio_idle_zero: assert property (!o_irq |-> o_irq_prio == 2'h0)
    else $error("priority shown with no request");
  a_reset_quiet: assert property ($past(i_rst) |-> o_pin == 16'h0 && &o_pin_oe_n)
    else $error("pins active after reset");
  a_oe_by_write: assert property ($changed(o_pin_oe_n) |-> $past(i_wr))
    else $error("pin enable moved without a write");
  a_en_readback: assert property (s_en_wr ##1 !i_wr ##1 s_en_rd |=>
    o_rdata == ($past(i_wdata, 3) & 32'h3FFFF))
    else $error("enable readback wrong");
  a_clr_reads_zero: assert property (i_rd && i_addr == ccu_pkg::ADR_IRQ_CLR |=> !o_rdata)
    else $error("clear register read not zero");
  a_mask_all: assert property (s_en_wr and i_wdata[17:0] == 18'h0 |=>
    o_irq_node == 18'h0 ##1 !o_irq)
    else $error("masked requests still shown");
endmodule

bind ccu_capture_compare ccu_capture_compare_monitor ccu_capture_compare_monitor_i (
  .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .o_pin(o_pin), .o_pin_oe_n(o_pin_oe_n),
  .o_irq_node(o_irq_node), .o_irq(o_irq), .o_irq_prio(o_irq_prio));

// ===== ccu_pin_partner.sv
// far side model: channel pin drivers and external count lines
`timescale 1ns/1ps
module ccu_pin_partner (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [15:0] i_toggle,
  input wire logic i_ext_step,
  input wire logic [15:0] i_dev_pin,
  input wire logic [15:0] i_dev_oe_n,
  output logic [15:0] o_pin,
  output logic [1:0] o_ext_cnt
);
  logic [15:0] lvl_q;
  logic [1:0] ext_q;
  always_ff @(posedge i_clk) begin
    lvl_q <= i_rst ? 16'h0 : lvl_q ^ i_toggle;
    ext_q <= i_rst ? 2'h0 : ext_q ^ {2{i_ext_step}};
  end
  // a pin the device enables shows its level, else the model's
  assign o_pin = (~i_dev_oe_n & i_dev_pin) | (i_dev_oe_n & lvl_q);
  assign o_ext_cnt = ext_q;
endmodule

// ===== ccu_capture_compare_test.sv
// self-checking bench for the capture/compare unit
`timescale 1ns/1ps
module ccu_capture_compare_test;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_aux_ovf = 1'b0;
  logic ext_step = 1'b0;
  logic [15:0] tog = 16'h0;
  logic [15:0] o_pin, o_pin_oe_n, pin_w;
  logic [31:0] o_rdata, v, ex, rd_v;
  logic [31:0] seed = 32'h00B6;
  logic [17:0] o_irq_node;
  logic [1:0] o_irq_prio, ext_w;
  logic o_irq, hit;
  int fails = 0, samples_checked = 0, cyc = 0, t, ch, n;
  always #2.5 i_clk = ~i_clk;
  ccu_capture_compare ccu_capture_compare_i (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pin(pin_w),
    .o_pin(o_pin), .o_pin_oe_n(o_pin_oe_n), .i_ext_cnt(ext_w), .i_aux_ovf(i_aux_ovf),
    .o_irq_node(o_irq_node), .o_irq(o_irq), .o_irq_prio(o_irq_prio));
  ccu_pin_partner ccu_pin_partner_i (.i_clk(i_clk), .i_rst(i_rst), .i_toggle(tog),
    .i_ext_step(ext_step), .i_dev_pin(o_pin), .i_dev_oe_n(o_pin_oe_n), .o_pin(pin_w),
    .o_ext_cnt(ext_w));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // count after k ticks; one wrap at most, reload taken on it
  function automatic logic [15:0] step(input logic [15:0] c, input logic [15:0] r, input int k);
    logic [16:0] s;
    s = {1'b0, c} + 17'(k);
    return s[16] ? r + s[15:0] : s[15:0];
  endfunction
  function automatic logic [7:0] ta(input logic [7:0] b);
    return b + 8'(4 * t);
  endfunction
  function automatic logic [7:0] ca(input logic [1:0] sel);
    return {sel, 4'(ch), 2'b00};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge i_clk);
  endtask
  // one idle cycle after each strobe so no strobe is set twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 rd_v = o_rdata;
    @(posedge i_clk);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      close_out();
    end
  end
  initial begin
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    chk({16'h0, o_pin_oe_n}, 32'hFFFF);
    repeat (6) begin
      v = rnd();
      wr(ccu_pkg::ADR_IRQ_EN, v);
      rd(ccu_pkg::ADR_IRQ_EN);
      chk(rd_v, v & 32'h3FFFF);
    end
    wr(ccu_pkg::ADR_IRQ_EN, 32'h0);
    rd(8'hFC);
    chk(rd_v, 32'h0);
    rd(ccu_pkg::ADR_IRQ_CLR);
    chk(rd_v, 32'h0);
    $display("register test done");
    for (t = 0; t < 2; t++) begin
      v = rnd() & 32'hFFFF;
      ex = 32'hFFFF - (rnd() & 32'h7);
      n = int'(rnd() & 32'h3);
      wr(ta(ccu_pkg::ADR_T_REL), v);
      wr(ta(ccu_pkg::ADR_T_CTRL), 32'h20);
      wr(ta(ccu_pkg::ADR_T_CNT), ex);
      idle(n);
      rd(ta(ccu_pkg::ADR_T_CNT));
      chk(rd_v, {16'h0, step(ex[15:0], v[15:0], n + 1)});
    end
    idle(8);
    rd(ccu_pkg::ADR_IRQ_STAT);
    chk(rd_v & 32'h30000, 32'h30000);
    $display("timer test done");
    for (int m = 1; m <= 3; m++) begin
      t = int'(rnd() & 32'h1);
      ch = int'(rnd() & 32'hF);
      ex = 32'h0;
      wr(ta(ccu_pkg::ADR_T_CTRL), 32'h0);
      wr(ca(ccu_pkg::ADR_CH_VAL_SEL), 32'h0);
      wr(ca(ccu_pkg::ADR_CH_CTRL_SEL), m | (t << 3));
      for (int k = 0; k < 2; k++) begin
        v = rnd() & 32'hFFFF;
        wr(ccu_pkg::ADR_IRQ_CLR, 32'h3FFFF);
        wr(ta(ccu_pkg::ADR_T_CNT), v);
        tog <= 16'h1 << ch;
        @(posedge i_clk);
        tog <= 16'h0;
        idle(6);
        hit = m == 3 || m == k + 1;
        if (hit) ex = v;
        rd(ca(ccu_pkg::ADR_CH_VAL_SEL));
        chk(rd_v, ex);
        rd(ccu_pkg::ADR_IRQ_STAT);
        chk({31'h0, rd_v[ch]}, {31'h0, hit});
      end
    end
    $display("capture test done");
    wr(ccu_pkg::ADR_IRQ_EN, 32'h3FFFF);
    // m == 8: toggle mode with the single event option
    for (int m = 4; m <= 8; m++) begin
      t = int'(rnd() & 32'h1);
      ch = int'(rnd() & 32'hF);
      v = 32'h8000 | (rnd() & 32'h7FFF);
      n = m == 8 ? 5 : m;
      wr(ta(ccu_pkg::ADR_T_REL), 32'h0);
      wr(ta(ccu_pkg::ADR_T_CTRL), 32'h20);
      wr(ta(ccu_pkg::ADR_T_CNT), 32'h0);
      wr(ca(ccu_pkg::ADR_CH_VAL_SEL), v);
      wr(ca(ccu_pkg::ADR_CH_CTRL_SEL), n | (t << 3) | (m == 8 ? 32'hE0 : 32'hC0));
      // pass 0 first match, pass 1 same period again, pass 2 overflow
      for (int p = 0; p < 3; p++) begin
        wr(ccu_pkg::ADR_IRQ_CLR, 32'h3FFFF);
        wr(ta(ccu_pkg::ADR_T_CNT), p == 2 ? 32'hFFFD : v - 32'h2);
        idle(6);
        hit = p == 0 || (p == 1 && m < 6);
        rd(ccu_pkg::ADR_IRQ_STAT);
        chk({31'h0, rd_v[ch]}, {31'h0, hit});
        chk({31'h0, o_pin[ch]}, 32'((p == 0 && n[0]) || (p > 0 && m == 8) || (p == 1 && m == 7)));
        chk({31'h0, o_irq_node[ch]}, {31'h0, hit});
        if (p == 0) chk({31'h0, o_irq}, 32'h1);
        if (p == 0) chk({30'h0, o_irq_prio}, 32'h3);
      end
      if (n[0]) chk({31'h0, o_pin_oe_n[ch]}, 32'h0);
    end
    // paired channels: lower pin toggles on a match of either register
    n = int'(rnd() & 32'h7);
    v = 32'h8000 | (rnd() & 32'h7E00);
    for (int q = 0; q < 2; q++) begin
      ch = n + 8 * q;
      wr(ca(ccu_pkg::ADR_CH_VAL_SEL), v + 32'((1 - q) << 8));
      wr(ca(ccu_pkg::ADR_CH_CTRL_SEL), 32'h4 | (t << 3) | (q << 4));
    end
    hit = o_pin[n];
    for (int q = 0; q < 2; q++) begin
      wr(ccu_pkg::ADR_IRQ_CLR, 32'h3FFFF);
      wr(ta(ccu_pkg::ADR_T_CNT), v - 32'h2 + 32'(q << 8));
      idle(6);
      rd(ccu_pkg::ADR_IRQ_STAT);
      chk({31'h0, rd_v[n + 8 - 8 * q]}, 32'h1);
      chk({31'h0, o_pin[n]}, {31'h0, hit ^ (q == 0)});
      chk({30'h0, o_pin_oe_n[n + 8], o_pin_oe_n[n]}, 32'h2);
    end
    wr(ccu_pkg::ADR_IRQ_EN, 32'h0);
    idle(1);
    chk({31'h0, o_irq}, 32'h0);
    chk({14'h0, o_irq_node}, 32'h0);
    $display("compare test done");
    // two reads 80 clocks apart, so the prescaler phase drops out for dividers 8 and 4, not 32
    for (int s = 0; s < 3; s++) begin
      n = s == 1 ? 2 : s;
      wr(ccu_pkg::ADR_GLOBAL, 32'(s != 1));
      wr(ta(ccu_pkg::ADR_T_CTRL), 32'h20 | n);
      wr(ta(ccu_pkg::ADR_T_CNT), 32'h0);
      rd(ta(ccu_pkg::ADR_T_CNT));
      v = rd_v;
      idle(78);
      rd(ta(ccu_pkg::ADR_T_CNT));
      chk(rd_v - v, 32'(80 / ((s != 1 ? 8 : 1) << n)));
    end
    wr(ccu_pkg::ADR_GLOBAL, 32'h0);
    $display("prescale test done");
    for (int s = 1; s <= 3; s++) begin
      wr(ta(ccu_pkg::ADR_T_CTRL), 32'h20 | (s << 3));
      wr(ta(ccu_pkg::ADR_T_CNT), 32'h0);
      repeat (4) begin
        ext_step <= 1'b1;
        i_aux_ovf <= 1'b1;
        @(posedge i_clk);
        ext_step <= 1'b0;
        i_aux_ovf <= 1'b0;
        idle(7);
      end
      rd(ta(ccu_pkg::ADR_T_CNT));
      chk(rd_v, s == 2 ? 32'h2 : 32'h4);
    end
    $display("source test done");
    close_out();
  end
endmodule
